// [design/eci_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Button-gate, contacts open: output off, toggles ignored, block indicator shown.
// - Button-gate, contacts shorted: front-panel toggles control the output.
// - Showing block indicator needs one escape press before toggles work.
// - Pin-drive: output follows contacts; front-panel toggle ignored.
// - Shut-off edge select chooses falling or rising edge.
// - Selected shut-off edge turns output off and latches indicator while the external gate is active.
// - Escape clears latch in any cycle with the input level steady, restored or not, before toggle accepted.
// - Only transitions cause shut-off, never steady levels.
// - Regulation-mode flag high in constant voltage, low in constant current.
// - Select input high or open gives local; low gives analog only while the external gate is active, otherwise local.
// - Analog control shows one fewer digit of resolution.
// - Control-source indicator high in local, low in analog.
// - Fault-free flag high normally, low on any fault.
// - Listed protection, line, enable, shut-off, remote, output-off faults clear flag.
// - Voltage programming active only in analog with voltage source.
// - Resistance source derives setpoint from external resistor.
// - One range setting picks ten or five full scale.
module eci_ctrl (
   // Clock and reset
   input  wire logic clk,
   input  wire logic srst,
   // Connector pins
   input  wire logic enable_contact_shorted,
   input  wire logic shutoff_pin,
   input  wire logic local_select_pin,
   // Menu settings
   input  wire logic ext_gate_active,
   input  wire logic enable_mode,
   input  wire logic shutoff_edge_sel,
   input  wire logic voltage_program_source,
   input  wire logic current_program_source,
   input  wire logic program_range,
   // Front panel and plant status
   input  wire logic key_toggle,
   input  wire logic key_escape,
   input  wire logic const_voltage,
   input  wire logic fault_ovp,
   input  wire logic fault_ocp,
   input  wire logic fault_otp,
   input  wire logic fault_ac_line,
   input  wire logic fault_remote,
   // Pin outputs
   output logic      regulation_mode_flag,
   output logic      local_state,
   output logic      power_ok,
   // Internal outputs
   output logic      output_on,
   output logic      enable_block_indicator,
   output logic      shutoff_indicator,
   output logic [1:0] digits_dropped,
   output logic      vprog_volt_en,
   output logic      vprog_res_en,
   output logic      iprog_volt_en,
   output logic      iprog_res_en,
   output logic      prog_range_low
);
   import eci_pkg::*;

   typedef struct packed {
      eci_out_st_t      out_st;
      logic             out_en;
      logic             so_prev;
      logic             so_latch;
      logic             ena_ind;
      logic             rmode;
      logic             local_st;
      logic             pok;
      logic [1:0]       digits;
      logic             vv;
      logic             vr;
      logic             iv;
      logic             ir;
      logic             rng;
   } eci_ctrl_st_t;

   eci_ctrl_st_t st_q;
   eci_ctrl_st_t st_d;

   logic [SYNC_W-1:0] pins_raw;
   logic [SYNC_W-1:0] pins_s;
   logic              ena_s;
   logic              so_s;
   logic              loc_s;
   logic              so_edge;
   logic              analog;
   logic              blocked;
   logic [FLT_W-1:0]  faults;

   // ==========================================================
   // Input synchronisation
   // ==========================================================
   assign pins_raw[SYNC_ENA] = enable_contact_shorted;
   assign pins_raw[SYNC_SO]  = shutoff_pin;
   assign pins_raw[SYNC_LOC] = local_select_pin;

   eci_sync u_sync (
      .clk      (clk),
      .srst     (srst),
      .pin_raw  (pins_raw),
      .pin_sync (pins_s)
   );

   assign ena_s = pins_s[SYNC_ENA];
   assign so_s  = pins_s[SYNC_SO];
   assign loc_s = pins_s[SYNC_LOC];

   // ==========================================================
   // Decode
   // ==========================================================
   // Edge compare uses the registered previous level, so a steady pin never fires.
   always_comb begin
      if (shutoff_edge_sel == SO_EDGE_RISING) begin
         so_edge = so_s & ~st_q.so_prev;
      end else begin
         so_edge = ~so_s & st_q.so_prev;
      end
   end

   assign analog  = ext_gate_active & ~loc_s;
   assign blocked = ext_gate_active & (enable_mode == ENA_MODE_BUTTON_GATE) & ~ena_s;

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb begin
      st_d         = st_q;
      st_d.so_prev = so_s;

      // Shut-off latch: an edge wins over an escape in the same cycle.
      if (ext_gate_active && so_edge) begin
         st_d.so_latch = 1'h1;
      end else if (key_escape && st_q.so_latch && so_s == st_q.so_prev) begin
         st_d.so_latch = 1'h0;
      end

      // Block indicator stays until escape once the contacts close, or until the gate goes inactive.
      if (blocked && key_toggle) begin
         st_d.ena_ind = 1'h1;
      end else if (blocked) begin
         st_d.ena_ind = 1'h1;
      end else if (key_escape || !ext_gate_active) begin
         st_d.ena_ind = 1'h0;
      end

      case (st_q.out_st)
         ECI_OFF: begin
            if (ext_gate_active && enable_mode == ENA_MODE_PIN_DRIVE) begin
               if (ena_s && !st_q.so_latch) begin
                  st_d.out_st = ECI_ON;
               end
            end else if (key_toggle && !blocked && !st_q.ena_ind
                         && !st_q.so_latch) begin
               st_d.out_st = ECI_ON;
            end
         end
         ECI_ON: begin
            if (ext_gate_active && enable_mode == ENA_MODE_PIN_DRIVE) begin
               if (!ena_s) begin
                  st_d.out_st = ECI_OFF;
               end
            end else if (key_toggle) begin
               st_d.out_st = ECI_OFF;
            end
            if (blocked) begin
               st_d.out_st = ECI_BLOCKED;
            end
         end
         ECI_BLOCKED: begin
            if (!blocked) begin
               st_d.out_st = ECI_OFF;
            end
         end
         default: begin
            st_d.out_st = ECI_OFF;
         end
      endcase
      // Shut-off overrides everything at once.
      if (ext_gate_active && so_edge) begin
         st_d.out_st = ECI_OFF;
      end
      st_d.out_en = (st_d.out_st == ECI_ON);

      st_d.rmode    = const_voltage;
      st_d.local_st = ~analog;
      st_d.digits   = analog ? DIGITS_REDUCED : DIGITS_FULL;
      st_d.vv  = analog & (voltage_program_source == PROG_SRC_VOLT);
      st_d.vr  = analog & (voltage_program_source == PROG_SRC_RES);
      st_d.iv  = analog & (current_program_source == PROG_SRC_VOLT);
      st_d.ir  = analog & (current_program_source == PROG_SRC_RES);
      st_d.rng = (program_range == PROG_RANGE_LOW);
      st_d.pok = ~|faults;
   end

   // The fault vector reflects the state being registered now.
   always_comb begin
      faults              = '0;
      faults[FLT_OVP]     = fault_ovp;
      faults[FLT_OCP]     = fault_ocp;
      faults[FLT_OTP]     = fault_otp;
      faults[FLT_AC]      = fault_ac_line;
      faults[FLT_ENABLE]  = ext_gate_active & ~ena_s;
      faults[FLT_SHUTOFF] = st_d.so_latch;
      faults[FLT_REMOTE]  = fault_remote;
      faults[FLT_OUTOFF]  = (st_d.out_st != ECI_ON);
   end

   // ==========================================================
   // State register
   // ==========================================================
   always_ff @(posedge clk) begin
      if (srst) begin
         st_q.out_st   <= ECI_OFF;
         st_q.out_en   <= 1'h0;
         st_q.so_prev  <= SYNC_RST[SYNC_SO];
         st_q.so_latch <= 1'h0;
         st_q.ena_ind  <= 1'h0;
         st_q.rmode    <= 1'h1;
         st_q.local_st <= 1'h1;
         st_q.pok      <= 1'h0;
         st_q.digits   <= DIGITS_FULL;
         st_q.vv       <= 1'h0;
         st_q.vr       <= 1'h0;
         st_q.iv       <= 1'h0;
         st_q.ir       <= 1'h0;
         st_q.rng      <= 1'h0;
      end else begin
         st_q <= st_d;
      end
   end

   assign regulation_mode_flag   = st_q.rmode;
   assign local_state            = st_q.local_st;
   assign power_ok               = st_q.pok;
   assign output_on              = st_q.out_en;
   assign enable_block_indicator = st_q.ena_ind;
   assign shutoff_indicator      = st_q.so_latch;
   assign digits_dropped         = st_q.digits;
   assign vprog_volt_en          = st_q.vv;
   assign vprog_res_en           = st_q.vr;
   assign iprog_volt_en          = st_q.iv;
   assign iprog_res_en           = st_q.ir;
   assign prog_range_low         = st_q.rng;

   // ==========================================================
   // Checks
   // ==========================================================
   blocked_off_a: assert property (@(posedge clk) disable iff (srst)
      blocked |=> !output_on) else $error("Output on while enable blocked.");

   block_ind_a: assert property (@(posedge clk) disable iff (srst)
      blocked |=> enable_block_indicator) else $error("Block indicator missing.");

   pin_drive_a: assert property (@(posedge clk) disable iff (srst)
      (ext_gate_active && enable_mode == ENA_MODE_PIN_DRIVE && !ena_s && !so_edge)
      |=> !output_on) else $error("Pin-drive open but output on.");

   so_trip_a: assert property (@(posedge clk) disable iff (srst)
      (ext_gate_active && so_edge) |=> (!output_on && shutoff_indicator))
      else $error("Shut-off edge not acted on.");

   so_steady_a: assert property (@(posedge clk) disable iff (srst)
      (!shutoff_indicator && $stable(so_s)) |=> !shutoff_indicator)
      else $error("Shut-off latched without an edge.");

   gate_local_a: assert property (@(posedge clk) disable iff (srst)
      !ext_gate_active |=> local_state) else $error("Analog while gate inactive.");

   pok_fault_a: assert property (@(posedge clk) disable iff (srst)
      (fault_ovp || fault_ocp || fault_otp || fault_ac_line || fault_remote)
      |=> !power_ok) else $error("Power ok high during fault.");

   rmode_a: assert property (@(posedge clk) disable iff (srst)
      1'b1 |=> regulation_mode_flag == $past(const_voltage))
      else $error("Regulation flag wrong.");

   local_src_a: assert property (@(posedge clk) disable iff (srst)
      analog |=> !local_state) else $error("Local state high in analog control.");

   digits_cut_a: assert property (@(posedge clk) disable iff (srst)
      analog |=> digits_dropped == DIGITS_REDUCED) else $error("Digits not reduced.");

   prog_idle_a: assert property (@(posedge clk) disable iff (srst)
      !analog |=> !(vprog_volt_en || vprog_res_en || iprog_volt_en || iprog_res_en))
      else $error("Programming enabled outside analog control.");

   res_src_a: assert property (@(posedge clk) disable iff (srst)
      (analog && voltage_program_source == PROG_SRC_RES) |=> (vprog_res_en && !vprog_volt_en))
      else $error("Resistance source not selected.");

   range_sel_a: assert property (@(posedge clk) disable iff (srst)
      (program_range == PROG_RANGE_LOW) |=> prog_range_low) else $error("Low range not shown.");

   toggle_refused_a: assert property (@(posedge clk) disable iff (srst)
      (key_toggle && enable_mode == ENA_MODE_BUTTON_GATE && !output_on
       && (enable_block_indicator || shutoff_indicator)) |=> !output_on)
      else $error("Toggle accepted while an indicator is showing.");

endmodule

`default_nettype wire

// [design/eci_pkg.sv]
package eci_pkg;

   // ==========================================================
   // Setting encodings
   // ==========================================================
   // Enable contact behaviour when the external gate is active.
   localparam logic ENA_MODE_BUTTON_GATE = 1'h0;
   localparam logic ENA_MODE_PIN_DRIVE   = 1'h1;

   // Shut-off edge select.
   localparam logic SO_EDGE_FALLING = 1'h0;
   localparam logic SO_EDGE_RISING  = 1'h1;

   // Program source select for voltage and current.
   localparam logic PROG_SRC_VOLT = 1'h0;
   localparam logic PROG_SRC_RES  = 1'h1;

   // Program range select.
   localparam logic PROG_RANGE_HIGH = 1'h0;
   localparam logic PROG_RANGE_LOW  = 1'h1;

   // ==========================================================
   // Fault vector layout
   // ==========================================================
   localparam int unsigned FLT_W       = 8;
   localparam int unsigned FLT_OVP     = 0;
   localparam int unsigned FLT_OCP     = 1;
   localparam int unsigned FLT_OTP     = 2;
   localparam int unsigned FLT_AC      = 3;
   localparam int unsigned FLT_ENABLE  = 4;
   localparam int unsigned FLT_SHUTOFF = 5;
   localparam int unsigned FLT_REMOTE  = 6;
   localparam int unsigned FLT_OUTOFF  = 7;

   // ==========================================================
   // Synchronised inputs
   // ==========================================================
   localparam int unsigned SYNC_W   = 3;
   localparam int unsigned SYNC_ENA = 0;
   localparam int unsigned SYNC_SO  = 1;
   localparam int unsigned SYNC_LOC = 2;
   localparam logic [2:0]  SYNC_RST = 3'h5;

   // Display digit reduction in analog control.
   localparam logic [1:0] DIGITS_FULL    = 2'h0;
   localparam logic [1:0] DIGITS_REDUCED = 2'h1;

   // ==========================================================
   // Output state machine
   // ==========================================================
   typedef enum logic [2:0] {
      ECI_OFF     = 3'h1,
      ECI_ON      = 3'h2,
      ECI_BLOCKED = 3'h4
   } eci_out_st_t;

endpackage

// [design/eci_sync.sv]
`timescale 1ns/10ps
`default_nettype none

module eci_sync (
   // Clock and reset
   input  wire logic                       clk,
   input  wire logic                       srst,
   // Raw pins and their synchronised copies
   input  wire logic [eci_pkg::SYNC_W-1:0] pin_raw,
   output logic      [eci_pkg::SYNC_W-1:0] pin_sync
);
   import eci_pkg::*;

   typedef struct packed {
      logic [SYNC_W-1:0] meta;
      logic [SYNC_W-1:0] sync;
   } eci_sync_st_t;

   eci_sync_st_t st_q;
   eci_sync_st_t st_d;

   // ==========================================================
   // Two-flop synchroniser
   // ==========================================================
   // The first stage feeds only the second stage.
   always_comb begin
      st_d      = st_q;
      st_d.meta = pin_raw;
      st_d.sync = st_q.meta;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_q.meta <= SYNC_RST;
         st_q.sync <= SYNC_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign pin_sync = st_q.sync;

endmodule

`default_nettype wire

// [testbench/eci_ext_model.sv]
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// External switches and trigger source
// ==========================================================
// Pins idle where an unwired connector leaves them: the select line is pulled up.
module eci_ext_model (
   // Connector pins
   output logic enable_contact_shorted,
   output logic shutoff_pin,
   output logic local_select_pin
);
   import eci_pkg::*;

   initial begin
      enable_contact_shorted = 1'h0;
      shutoff_pin            = 1'h0;
      local_select_pin       = 1'h1;
   end

   task automatic set_enable(input logic v);
      enable_contact_shorted = v;
   endtask

   task automatic set_shutoff(input logic v);
      shutoff_pin = v;
   endtask

   // Brings the pin back to its idle level; escape clears the latch whether or not it has been restored.
   task automatic restore_shutoff(input logic sel);
      shutoff_pin = (sel == SO_EDGE_FALLING) ? 1'h1 : 1'h0;
   endtask

   task automatic set_local(input logic v);
      local_select_pin = v;
   endtask
endmodule

`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none

`define ECI_CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin error_cnt++; \
   $display("ERROR %0t: got %b expected %b", $time, (got), (exp)); end end

module tb_top;
   import eci_pkg::*;

   // ==========================================================
   // Signals
   // ==========================================================
   logic clk, srst, gate, mode, edge_sel, vsrc, isrc, range, k_tog, k_esc, cv;
   logic [4:0] flt;
   logic [2:0] c;
   wire logic  ena_pin, so_pin, loc_pin;
   logic reg_flag, loc_st, pok, out_on, blk_ind, so_ind, v_v, v_r, i_v, i_r, rng_lo;
   logic [1:0] digits;
   int error_cnt;
   int cmp_count;

   eci_ext_model ext_u (
      .enable_contact_shorted (ena_pin),
      .shutoff_pin            (so_pin),
      .local_select_pin       (loc_pin)
   );

   eci_ctrl dut_u (
      .clk (clk), .srst (srst),
      .enable_contact_shorted (ena_pin), .shutoff_pin (so_pin), .local_select_pin (loc_pin),
      .ext_gate_active (gate), .enable_mode (mode), .shutoff_edge_sel (edge_sel),
      .voltage_program_source (vsrc), .current_program_source (isrc),
      .program_range (range), .key_toggle (k_tog), .key_escape (k_esc), .const_voltage (cv),
      .fault_ovp (flt[0]), .fault_ocp (flt[1]), .fault_otp (flt[2]),
      .fault_ac_line (flt[3]), .fault_remote (flt[4]),
      .regulation_mode_flag (reg_flag), .local_state (loc_st), .power_ok (pok),
      .output_on (out_on), .enable_block_indicator (blk_ind), .shutoff_indicator (so_ind),
      .digits_dropped (digits), .vprog_volt_en (v_v), .vprog_res_en (v_r),
      .iprog_volt_en (i_v), .iprog_res_en (i_r), .prog_range_low (rng_lo)
   );

   // ==========================================================
   // Clock, tasks and verdict
   // ==========================================================
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end

   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask

   // A key press is high across exactly one rising edge.
   task automatic press(input bit esc);
      if (esc) begin
         k_esc = 1'h1;
      end else begin
         k_tog = 1'h1;
      end
      step(1);
      k_esc = 1'h0;
      k_tog = 1'h0;
      step(2);
   endtask

   task automatic final_report();
      $display("errors %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // A hang anywhere ends the run as a failure.
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      final_report();
   end

   // ==========================================================
   // Scenarios
   // ==========================================================
   initial begin
      {gate, mode, edge_sel, vsrc, isrc, range, k_tog, k_esc} = 8'h00;
      cv = 1'h1;
      flt = 5'h00;
      srst = 1'h1;
      step(5);
      srst = 1'h0;
      `ECI_CHK({out_on, blk_ind, so_ind, reg_flag, loc_st, pok, digits}, 8'h18)
      // Gate inactive: pins ignored, front panel in charge.
      ext_u.set_local(1'h0);
      ext_u.set_shutoff(1'h1);
      step(4);
      ext_u.set_shutoff(1'h0);
      step(4);
      `ECI_CHK(loc_st, 1'h1)
      `ECI_CHK(pok, 1'h0)
      press(0);
      `ECI_CHK({out_on, so_ind, pok}, 3'h5)
      for (int v = 0; v < 2; v++) begin
         cv = ~cv;
         step(2);
         `ECI_CHK(reg_flag, logic'(v))
      end
      for (int i = 0; i < 5; i++) begin
         flt[i] = ~flt[i];
         step(3);
         `ECI_CHK(pok, 1'h0)
         flt[i] = ~flt[i];
         step(3);
         `ECI_CHK(pok, 1'h1)
      end
      ext_u.set_local(1'h1);
      // Button-gate with contacts open, then shorted.
      ext_u.set_enable(1'h0);
      gate = ~gate;
      step(4);
      `ECI_CHK({out_on, blk_ind, pok}, 3'h2)
      press(0);
      `ECI_CHK(out_on, 1'h0)
      ext_u.set_enable(1'h1);
      step(4);
      press(0);
      `ECI_CHK(out_on, 1'h0)
      press(1);
      `ECI_CHK(blk_ind, 1'h0)
      press(0);
      `ECI_CHK({out_on, pok}, 2'h3)
      // Shut-off on each edge kind; steady levels never trip it.
      for (int s = 0; s < 2; s++) begin
         edge_sel = s[0];
         step(1);
         ext_u.restore_shutoff(edge_sel);
         step(20);
         `ECI_CHK({out_on, so_ind}, 2'h2)
         ext_u.set_shutoff(edge_sel);
         step(4);
         `ECI_CHK({out_on, so_ind, pok}, 3'h2)
         press(0);
         `ECI_CHK(out_on, 1'h0)
         ext_u.restore_shutoff(edge_sel);
         step(4);
         `ECI_CHK(so_ind, 1'h1)
         press(1);
         `ECI_CHK(so_ind, 1'h0)
         press(0);
         `ECI_CHK(out_on, 1'h1)
      end
      // Mode change done the safe way: gate off, pick pin-drive, gate back on.
      gate = ~gate;
      step(2);
      mode = ENA_MODE_PIN_DRIVE;
      press(1);
      `ECI_CHK(blk_ind, 1'h0)
      gate = ~gate;
      ext_u.set_enable(1'h0);
      step(4);
      `ECI_CHK({out_on, blk_ind}, 2'h0)
      press(0);
      `ECI_CHK(out_on, 1'h0)
      ext_u.set_enable(1'h1);
      step(4);
      press(0);
      `ECI_CHK(out_on, 1'h1)
      // Analog control and program source decoding.
      ext_u.set_local(1'h0);
      step(4);
      `ECI_CHK(loc_st, 1'h0)
      `ECI_CHK(digits, DIGITS_REDUCED)
      for (int i = 0; i < 8; i++) begin
         c = i[2:0];
         {range, isrc, vsrc} = c;
         step(2);
         `ECI_CHK({v_v, v_r}, {vsrc == PROG_SRC_VOLT, vsrc == PROG_SRC_RES})
         `ECI_CHK({i_v, i_r}, {isrc == PROG_SRC_VOLT, isrc == PROG_SRC_RES})
         `ECI_CHK(rng_lo, logic'(range == PROG_RANGE_LOW))
      end
      ext_u.set_local(1'h1);
      step(4);
      `ECI_CHK({loc_st, v_v, v_r, i_v, i_r}, 5'h10)
      `ECI_CHK(digits, DIGITS_FULL)
      final_report();
   end
endmodule

`undef ECI_CHK
`default_nettype wire
